//--- hdl/tx_power_cfg.svh
`ifndef TX_POWER_CFG_SVH
`define TX_POWER_CFG_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define TX_CLK_HZ      26'h2FAF080
`define TX_HALF_CYC    26'h17D7840
`define TX_DUTY_CYC    26'h000C350
`define TX_PING_WIN_MS 70
`define TX_PAUSE_MS    10

// ---------------------------------------------------------------
// operating window (Hz and 0.1 % units)
// ---------------------------------------------------------------
`define TX_F_MIN       18'h1ADB0
`define TX_F_MAX       18'h320C8
`define TX_F_PING      18'h2AB98
`define TX_F_STEP      18'h01388
`define TX_DUTY_HALF   9'h1F4
`define TX_DUTY_MIN    9'h014

// ---------------------------------------------------------------
// loop constants
// ---------------------------------------------------------------
`define TX_LOOP_LIMIT  16'sh4E20
`define TX_KP          1
`define TX_CE_SHIFT    7
`define TX_CUR_MAX     12'hFFF

// ---------------------------------------------------------------
// message headers
// ---------------------------------------------------------------
`define TX_HDR_SS      8'h01
`define TX_HDR_END     8'h02
`define TX_HDR_CE      8'h03

`endif

//--- hdl/tx_power_pkg.sv
package tx_power_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'b0001,
		ST_PING  = 4'b0010,
		ST_POWER = 4'b0100,
		ST_PAUSE = 4'b1000
	} tx_state_type;

endpackage : tx_power_pkg

//--- hdl/loop_gain.sv
`timescale 1ns/100ps
`default_nettype none
`include "tx_power_cfg.svh"

module loop_gain
#(
	parameter int KP = `TX_KP
)
(
	// operands in mA
	input  wire logic [11:0]        i_target_ma,
	input  wire logic [11:0]        i_meas_ma,
	// clamped loop output
	output logic signed [15:0]      o_out
);

	logic signed [12:0] err;
	logic signed [31:0] prod;

	assign err  = $signed({1'b0, i_target_ma}) - $signed({1'b0, i_meas_ma});
	assign prod = 32'(err) * KP;

	// proportional only: integral and derivative terms are zero
	always_comb
	begin
		if (prod > 32'(`TX_LOOP_LIMIT))
			o_out = `TX_LOOP_LIMIT;
		else if (prod < -32'(`TX_LOOP_LIMIT))
			o_out = -`TX_LOOP_LIMIT;
		else
			o_out = prod[15:0];
	end

endmodule : loop_gain

`default_nettype wire

//--- hdl/bridge_pwm.sv
`timescale 1ns/100ps
`default_nettype none
`include "tx_power_cfg.svh"

module bridge_pwm
#(
	parameter int ACC_W = 26,
	parameter int F_W   = 18,
	parameter int D_W   = 9
)
(
	// clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_sys_rst,
	// settings
	input  wire logic               i_run,
	input  wire logic [F_W-1:0]     i_freq_hz,
	input  wire logic [D_W-1:0]     i_duty,
	// bridge legs
	output logic                    o_leg_a,
	output logic                    o_leg_b
);

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic [ACC_W:0]   acc_sum;
	logic [ACC_W-1:0] thr;
	logic             leg_a_nxt;
	logic             leg_b_nxt;

	// ---------------------------------------------------------------
	// phase accumulator
	// ---------------------------------------------------------------
	// modulo-clock accumulator gives 1 Hz resolution; edges jitter
	// by one clock but the mean frequency is exact
	assign acc_sum = {1'b0, acc_r} + (ACC_W+1)'(i_freq_hz);
	assign thr     = ACC_W'(i_duty) * `TX_DUTY_CYC;

	always_comb
	begin
		if (!i_run)
			acc_nxt = '0;
		else if (acc_sum >= {1'b0, `TX_CLK_HZ})
			acc_nxt = ACC_W'(acc_sum - {1'b0, `TX_CLK_HZ});
		else
			acc_nxt = acc_sum[ACC_W-1:0];
		// each leg conducts for the duty share of the whole period, starting at its own half
		leg_a_nxt = i_run && (acc_r < thr);
		leg_b_nxt = i_run && (acc_r >= `TX_HALF_CYC) && (acc_r < `TX_HALF_CYC + thr);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			acc_r   <= '0;
			o_leg_a <= 1'b0;
			o_leg_b <= 1'b0;
		end
		else
		begin
			acc_r   <= acc_nxt;
			o_leg_a <= leg_a_nxt;
			o_leg_b <= leg_b_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_legs_excl;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		!(o_leg_a && o_leg_b);
	endproperty
	a_legs_excl: assert property (p_legs_excl) else $error("both bridge legs on");

endmodule : bridge_pwm

`default_nettype wire

//--- hdl/inductive_tx_power_loop.sv
// Behaviour
// - decode receiver messages, drive the power loop
// - frequency 110 to 205 kHz at 50 % duty
// - at 205 kHz duty may drop to 2 %
// - higher frequency or lower duty lowers power
// - frequency steps of 0.5 kHz or finer
// - duty steps of 0.1 % or finer
// - ping starts at 175 kHz, 50 % duty
// - no signal strength after ping: stop driving
// - retry ping at successively lower frequencies (5 kHz steps down to 110 kHz, then wraps back to 175 kHz)
// - loop controls frequency or duty cycle
// - coil current measured to 5 mA or finer
// - frequency loop: gain 1, limit 20000, 1 Hz
// - duty loop: gain 1, limit 20000, 0.1 %
`timescale 1ns/100ps
`default_nettype none
`include "tx_power_cfg.svh"

module inductive_tx_power_loop
#(
	parameter int PING_WIN_MS  = `TX_PING_WIN_MS,
	parameter int PAUSE_MS     = `TX_PAUSE_MS,
	parameter int PING_WIN_CYC = PING_WIN_MS * (`TX_CLK_HZ / 1000),
	parameter int PAUSE_CYC    = PAUSE_MS * (`TX_CLK_HZ / 1000),
	parameter int CNT_W        = 23
)
(
	// clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_sys_rst,
	// enable pin
	input  wire logic               i_tx_enable,
	// decoded packets from the demodulator
	input  wire logic               i_pkt_valid,
	input  wire logic [7:0]         i_pkt_header,
	input  wire logic [7:0]         i_pkt_data,
	// coil current amplitude in mA
	input  wire logic               i_cur_valid,
	input  wire logic [11:0]        i_cur_ma,
	// inverter drive
	output logic                    o_bridge_a,
	output logic                    o_bridge_b,
	// status
	output logic                    o_drive_on,
	output logic [17:0]             o_freq_hz,
	output logic [8:0]              o_duty,
	output logic                    o_ping_fail,
	output logic                    o_in_power
);

	tx_power_pkg::tx_state_type st_r;
	tx_power_pkg::tx_state_type st_nxt;

	logic              en_meta_r;
	logic              en_s_r;
	logic [17:0]       freq_r;
	logic [17:0]       freq_nxt;
	logic [8:0]        duty_r;
	logic [8:0]        duty_nxt;
	logic [17:0]       ping_r;
	logic [17:0]       ping_nxt;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [11:0]       tgt_r;
	logic [11:0]       tgt_nxt;
	logic [11:0]       cur_r;
	logic [11:0]       cur_nxt;
	logic              pend_r;
	logic              pend_nxt;
	logic              fail_nxt;
	logic              drive_nxt;

	logic              ss_pkt;
	logic              end_pkt;
	logic              ce_pkt;
	logic              upd;
	logic signed [15:0] loop_out;
	logic [19:0]       mag;
	logic [17:0]       f_up;
	logic [17:0]       f_dn;
	logic [8:0]        d_up;
	logic [8:0]        d_dn;
	logic signed [20:0] ce_prod;
	logic signed [21:0] ce_sum;
	logic [11:0]       ce_tgt;

	// ---------------------------------------------------------------
	// enable pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			en_meta_r <= 1'b0;
			en_s_r    <= 1'b0;
		end
		else
		begin
			en_meta_r <= i_tx_enable;
			en_s_r    <= en_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// message decode and loop arithmetic
	// ---------------------------------------------------------------
	assign ss_pkt  = i_pkt_valid && (i_pkt_header == `TX_HDR_SS);
	assign end_pkt = i_pkt_valid && (i_pkt_header == `TX_HDR_END);
	assign ce_pkt  = i_pkt_valid && (i_pkt_header == `TX_HDR_CE);
	assign upd     = (st_r == tx_power_pkg::ST_POWER) && en_s_r && !end_pkt
		&& !ce_pkt && pend_r && i_cur_valid;

	// control error scales the last current: target = i * (1 + e/128)
	assign ce_prod = $signed({1'b0, cur_r}) * $signed(i_pkt_data);
	assign ce_sum  = $signed({10'h000, cur_r}) + 22'(ce_prod >>> `TX_CE_SHIFT);
	assign ce_tgt  = (ce_sum < 0) ? 12'h000 :
		(ce_sum > $signed({10'h000, `TX_CUR_MAX})) ? `TX_CUR_MAX : ce_sum[11:0];

	loop_gain u_gain
	(
		.i_target_ma (tgt_r),
		.i_meas_ma   (i_cur_ma),
		.o_out       (loop_out)
	);

	// one output unit is 1 Hz or 0.1 % duty; clamps keep the window
	assign mag  = loop_out[15] ? 20'(-loop_out) : 20'(loop_out);
	assign f_up = ({2'h0, freq_r} + mag > {2'h0, `TX_F_MAX}) ? `TX_F_MAX
		: 18'({2'h0, freq_r} + mag);
	assign f_dn = ({2'h0, freq_r} < mag + {2'h0, `TX_F_MIN}) ? `TX_F_MIN
		: 18'({2'h0, freq_r} - mag);
	assign d_up = ({11'h000, duty_r} + mag > {11'h000, `TX_DUTY_HALF}) ? `TX_DUTY_HALF
		: 9'({11'h000, duty_r} + mag);
	assign d_dn = ({11'h000, duty_r} < mag + {11'h000, `TX_DUTY_MIN}) ? `TX_DUTY_MIN
		: 9'({11'h000, duty_r} - mag);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt   = st_r;
		freq_nxt = freq_r;
		duty_nxt = duty_r;
		ping_nxt = ping_r;
		cnt_nxt  = cnt_r;
		tgt_nxt  = tgt_r;
		pend_nxt = pend_r;
		fail_nxt = 1'b0;
		cur_nxt  = i_cur_valid ? i_cur_ma : cur_r;
		case (st_r)
			tx_power_pkg::ST_IDLE:
			begin
				if (en_s_r)
				begin
					st_nxt   = tx_power_pkg::ST_PING;
					freq_nxt = `TX_F_PING;
					duty_nxt = `TX_DUTY_HALF;
					ping_nxt = `TX_F_PING;
					cnt_nxt  = CNT_W'(PING_WIN_CYC - 1);
				end
			end
			tx_power_pkg::ST_PING:
			begin
				if (!en_s_r)
					st_nxt = tx_power_pkg::ST_IDLE;
				else if (ss_pkt)
				begin
					st_nxt   = tx_power_pkg::ST_POWER;
					pend_nxt = 1'b0;
					tgt_nxt  = cur_r;
				end
				else if (cnt_r == '0)
				begin
					// nothing heard: drop the power signal
					st_nxt   = tx_power_pkg::ST_PAUSE;
					fail_nxt = 1'b1;
					cnt_nxt  = CNT_W'(PAUSE_CYC - 1);
					// next attempt lower, wrapping once the bottom is passed
					if (ping_r < `TX_F_MIN + `TX_F_STEP)
						ping_nxt = `TX_F_PING;
					else
						ping_nxt = ping_r - `TX_F_STEP;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			tx_power_pkg::ST_PAUSE:
			begin
				if (!en_s_r)
					st_nxt = tx_power_pkg::ST_IDLE;
				else if (cnt_r == '0)
				begin
					st_nxt   = tx_power_pkg::ST_PING;
					freq_nxt = ping_r;
					duty_nxt = `TX_DUTY_HALF;
					cnt_nxt  = CNT_W'(PING_WIN_CYC - 1);
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			tx_power_pkg::ST_POWER:
			begin
				if (!en_s_r || end_pkt)
					st_nxt = tx_power_pkg::ST_IDLE;
				else if (ce_pkt)
				begin
					// one update per message: a pure P term must not ramp
					tgt_nxt  = ce_tgt;
					pend_nxt = 1'b1;
				end
				else if (upd)
				begin
					pend_nxt = 1'b0;
					if (loop_out < 0)
					begin
						// less power: frequency first, duty only at the top
						if (freq_r < `TX_F_MAX)
							freq_nxt = f_up;
						else
							duty_nxt = d_dn;
					end
					else if (loop_out > 0)
					begin
						// more power: restore duty before lowering frequency
						if (duty_r < `TX_DUTY_HALF)
							duty_nxt = d_up;
						else
							freq_nxt = f_dn;
					end
				end
			end
			default:
				st_nxt = tx_power_pkg::ST_IDLE;
		endcase
		drive_nxt = (st_nxt == tx_power_pkg::ST_PING) || (st_nxt == tx_power_pkg::ST_POWER);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			st_r        <= tx_power_pkg::ST_IDLE;
			freq_r      <= `TX_F_PING;
			duty_r      <= `TX_DUTY_HALF;
			ping_r      <= `TX_F_PING;
			cnt_r       <= '0;
			tgt_r       <= '0;
			cur_r       <= '0;
			pend_r      <= 1'b0;
			o_ping_fail <= 1'b0;
			o_drive_on  <= 1'b0;
			o_in_power  <= 1'b0;
		end
		else
		begin
			st_r        <= st_nxt;
			freq_r      <= freq_nxt;
			duty_r      <= duty_nxt;
			ping_r      <= ping_nxt;
			cnt_r       <= cnt_nxt;
			tgt_r       <= tgt_nxt;
			cur_r       <= cur_nxt;
			pend_r      <= pend_nxt;
			o_ping_fail <= fail_nxt;
			o_drive_on  <= drive_nxt;
			o_in_power  <= (st_nxt == tx_power_pkg::ST_POWER);
		end
	end

	assign o_freq_hz = freq_r;
	assign o_duty    = duty_r;

	// ---------------------------------------------------------------
	// inverter waveform
	// ---------------------------------------------------------------
	bridge_pwm u_pwm
	(
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_run     (o_drive_on),
		.i_freq_hz (freq_r),
		.i_duty    (duty_r),
		.o_leg_a   (o_bridge_a),
		.o_leg_b   (o_bridge_b)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_range;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		o_drive_on |-> (o_freq_hz >= `TX_F_MIN && o_freq_hz <= `TX_F_MAX
			&& o_duty >= `TX_DUTY_MIN && o_duty <= `TX_DUTY_HALF);
	endproperty
	a_range: assert property (p_range) else $error("drive outside window");

	property p_duty_at_max;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_duty < `TX_DUTY_HALF) |-> (o_freq_hz == `TX_F_MAX);
	endproperty
	a_duty_at_max: assert property (p_duty_at_max) else $error("duty cut below top");

	property p_ping_start;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r == tx_power_pkg::ST_IDLE && en_s_r) |=>
			(o_drive_on && o_freq_hz == `TX_F_PING && o_duty == `TX_DUTY_HALF);
	endproperty
	a_ping_start: assert property (p_ping_start) else $error("bad first ping");

	property p_timeout;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r == tx_power_pkg::ST_PING && en_s_r && cnt_r == '0 && !ss_pkt)
			|=> (!o_drive_on && o_ping_fail) ##1 (!o_bridge_a && !o_bridge_b);
	endproperty
	a_timeout: assert property (p_timeout) else $error("ping not removed");

	property p_retry;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r == tx_power_pkg::ST_PAUSE && cnt_r == '0 && en_s_r) |=>
			(o_drive_on && (o_freq_hz < $past(o_freq_hz) || o_freq_hz == `TX_F_PING));
	endproperty
	a_retry: assert property (p_retry) else $error("retry not lower");

	property p_decode;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r == tx_power_pkg::ST_PING && en_s_r && ss_pkt) |=> (o_in_power && o_drive_on);
	endproperty
	a_decode: assert property (p_decode) else $error("strength not taken");

	property p_end;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		// legs drop one edge after drive; a held enable re-pings right after
		(st_r == tx_power_pkg::ST_POWER && end_pkt) |=> !o_drive_on ##1 (!o_bridge_a && !o_bridge_b);
	endproperty
	a_end: assert property (p_end) else $error("end not obeyed");

	property p_reduce;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(upd && loop_out < 0 && freq_r < `TX_F_MAX) |=>
			(o_freq_hz > $past(o_freq_hz) && o_duty == $past(o_duty));
	endproperty
	a_reduce: assert property (p_reduce) else $error("reduce path wrong");

	property p_raise;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(upd && loop_out > 0 && duty_r == `TX_DUTY_HALF) |=>
			(o_freq_hz <= $past(o_freq_hz) && o_duty == `TX_DUTY_HALF);
	endproperty
	a_raise: assert property (p_raise) else $error("raise path wrong");

	property p_loop_limit;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		upd |-> (loop_out <= `TX_LOOP_LIMIT && loop_out >= -`TX_LOOP_LIMIT);
	endproperty
	a_loop_limit: assert property (p_loop_limit) else $error("loop out of limit");

	property p_only_power;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r != tx_power_pkg::ST_POWER) |=> $stable(o_duty) || o_duty == `TX_DUTY_HALF;
	endproperty
	a_only_power: assert property (p_only_power) else $error("duty moved off loop");

	c_retry: cover property (@(posedge i_sys_clk) o_ping_fail ##1 !o_drive_on);
	c_power: cover property (@(posedge i_sys_clk) $rose(o_in_power));
	c_duty_cut: cover property (@(posedge i_sys_clk) o_in_power && o_duty < `TX_DUTY_HALF);

endmodule : inductive_tx_power_loop

`default_nettype wire

//--- verification/power_rx_model.sv
`timescale 1ns/100ps
`default_nettype none

module power_rx_model
(
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_sys_rst,
	// bench control
	input  wire logic       i_answer,
	input  wire logic       i_req,
	input  wire logic [7:0] i_hdr,
	input  wire logic [7:0] i_data,
	// link side
	input  wire logic       i_drive_on,
	output logic            o_pkt_valid,
	output logic [7:0]      o_pkt_header,
	output logic [7:0]      o_pkt_data
);

	logic [5:0] wait_r;

	// released lines toggle each cycle between the last value and its inverse
	always_ff @(posedge i_sys_clk)
	begin
		o_pkt_valid  <= 1'b0;
		o_pkt_header <= ~o_pkt_header;
		o_pkt_data   <= ~o_pkt_data;
		if (i_sys_rst || !i_drive_on)
			wait_r <= 6'h00;
		else if (wait_r != 6'h3F)
			wait_r <= wait_r + 6'h01;
		if (i_sys_rst)
		begin
			o_pkt_header <= 8'h00;
			o_pkt_data   <= 8'h00;
		end
		else if (i_req)
		begin
			o_pkt_valid  <= 1'b1;
			o_pkt_header <= i_hdr;
			o_pkt_data   <= i_data;
		end
		// signal strength only while powered, some time after power appears
		else if (i_answer && i_drive_on && wait_r == 6'h14)
		begin
			o_pkt_valid  <= 1'b1;
			o_pkt_header <= 8'h01;
			o_pkt_data   <= 8'h80;
		end
	end

endmodule : power_rx_model

`default_nettype wire

//--- verification/tb_inductive_tx_power_loop.sv
`timescale 1ns/100ps
`default_nettype none

module tb_inductive_tx_power_loop;

	logic        i_sys_clk   = 1'b0;
	logic        i_sys_rst   = 1'b1;
	logic        i_tx_enable = 1'b0;
	logic        answer      = 1'b0;
	logic        req         = 1'b0;
	logic [7:0]  hdr         = 8'h00;
	logic [7:0]  data        = 8'h00;
	logic        i_cur_valid = 1'b0;
	logic [11:0] i_cur_ma    = 12'h000;
	logic        pkt_valid;
	logic [7:0]  pkt_header;
	logic [7:0]  pkt_data;
	logic        o_bridge_a;
	logic        o_bridge_b;
	logic        o_drive_on;
	logic [17:0] o_freq_hz;
	logic [8:0]  o_duty;
	logic        o_ping_fail;
	logic        o_in_power;
	int          err_count   = 0;
	int          checked     = 0;
	int          ef;
	int          ed;
	int          pf;

	always #10 i_sys_clk = ~i_sys_clk;

	power_rx_model rx
	(
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_answer(answer), .i_req(req),
		.i_hdr(hdr), .i_data(data), .i_drive_on(o_drive_on), .o_pkt_valid(pkt_valid),
		.o_pkt_header(pkt_header), .o_pkt_data(pkt_data)
	);

	inductive_tx_power_loop #(.PING_WIN_CYC(1000), .PAUSE_CYC(50)) uut
	(
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_tx_enable(i_tx_enable),
		.i_pkt_valid(pkt_valid), .i_pkt_header(pkt_header), .i_pkt_data(pkt_data),
		.i_cur_valid(i_cur_valid), .i_cur_ma(i_cur_ma), .o_bridge_a(o_bridge_a),
		.o_bridge_b(o_bridge_b), .o_drive_on(o_drive_on), .o_freq_hz(o_freq_hz),
		.o_duty(o_duty), .o_ping_fail(o_ping_fail), .o_in_power(o_in_power)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// loop output expected from one current sample, one control error and one measured current
	function automatic int loop_exp(input int c0, input int e, input int m);
		int t;
		t = c0 + ((c0 * e) >>> 7);
		t = (t < 0) ? 0 : (t > 4095) ? 4095 : t;
		t = t - m;
		return (t > 20000) ? 20000 : (t < -20000) ? -20000 : t;
	endfunction : loop_exp

	task automatic near(input int g, input int e, input int t);
		chk((g >= e - t && g <= e + t) ? e : g, e);
	endtask : near

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : tick

	task automatic report_and_stop();
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// 0: drive, 1: ping failure pulse, 2: power state
	task automatic wait_on(input int sel, input logic v);
		logic s;
		for (int k = 0; k < 3000; k++)
		begin
			@(posedge i_sys_clk);
			#1;
			s = (sel == 0) ? o_drive_on : (sel == 1) ? o_ping_fail : o_in_power;
			if (s === v)
				return;
		end
		err_count++;
		report_and_stop();
	endtask : wait_on

	task automatic send(input logic [7:0] h, input logic [7:0] d);
		@(posedge i_sys_clk);
		req  <= 1'b1;
		hdr  <= h;
		data <= d;
		@(posedge i_sys_clk);
		req  <= 1'b0;
	endtask : send

	task automatic cur(input int v);
		@(posedge i_sys_clk);
		i_cur_valid <= 1'b1;
		i_cur_ma    <= v[11:0];
		@(posedge i_sys_clk);
		i_cur_valid <= 1'b0;
		i_cur_ma    <= ~v[11:0];
	endtask : cur

	// one current sample, one control error message, then a second current sample
	task automatic step(input int c0, input int e, input int m);
		int o;
		cur(c0);
		tick(2);
		send(8'h03, e[7:0]);
		tick(2);
		cur(m);
		tick(2);
		#1;
		o = loop_exp(c0, e, m);
		if (o < 0)
		begin
			if (ef < 205000)
				ef = (ef - o > 205000) ? 205000 : ef - o;
			else
				ed = (ed + o < 20) ? 20 : ed + o;
		end
		else if (o > 0)
		begin
			if (ed < 500)
				ed = (ed + o > 500) ? 500 : ed + o;
			else
				ef = (ef - o < 110000) ? 110000 : ef - o;
		end
		chk(o_freq_hz, ef);
		chk(o_duty, ed);
	endtask : step

	// 10000 cycles of 20 ns: edges = f / 5000, high cycles = duty * 10
	task automatic measure();
		int   ne;
		int   nh;
		int   nb;
		logic pa;
		ne = 0;
		nh = 0;
		nb = 0;
		pa = o_bridge_a;
		repeat (10000)
		begin
			@(posedge i_sys_clk);
			#1;
			if (o_bridge_a === 1'b1 && pa === 1'b0)
				ne++;
			if (o_bridge_a === 1'b1)
				nh++;
			if (o_bridge_b === 1'b1)
				nb++;
			if (o_bridge_a === 1'b1 && o_bridge_b === 1'b1)
				chk(32'h1, 32'h0);
			pa = o_bridge_a;
		end
		near(ne, ef / 5000, 1);
		near(nh, ed * 10, ne + 2);
		near(nb, ed * 10, ne + 2);
	endtask : measure

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h9200));
		tick(8);
		i_sys_rst <= 1'b0;
		@(posedge i_sys_clk);
		#1;
		chk(o_freq_hz, 32'h0002AB98);
		chk(o_duty, 32'h000001F4);
		chk({o_drive_on, o_in_power, o_bridge_a, o_bridge_b}, 32'h0);
		@(posedge i_sys_clk);
		i_tx_enable <= 1'b1;
		pf = 175000;
		// unanswered pings walk down, then wrap back to the start frequency
		for (int i = 0; i < 14; i++)
		begin
			wait_on(0, 1'b1);
			chk(o_freq_hz, pf);
			chk(o_duty, 32'h000001F4);
			wait_on(1, 1'b1);
			tick(1);
			#1;
			chk(o_drive_on, 32'h0);
			pf = (pf < 115000) ? 175000 : pf - 5000;
		end
		@(posedge i_sys_clk);
		answer <= 1'b1;
		wait_on(2, 1'b1);
		chk(o_freq_hz, pf);
		ef = pf;
		ed = 500;
		measure();
		for (int i = 0; i < 10; i++)
			step(0, 0, 4095);
		measure();
		step(100, 0, 99);
		step(100, 0, 101);
		for (int i = 0; i < 26; i++)
			step(4095, 0, 0);
		step(100, 0, 101);
		step(100, 0, 99);
		step(4095, -128, 0);
		step(4095, 127, 0);
		for (int i = 0; i < 60; i++)
			step($urandom_range(4095), int'($urandom_range(255)) - 128,
				$urandom_range(4095));
		answer <= 1'b0;
		send(8'h02, 8'h00);
		wait_on(0, 1'b0);
		tick(1);
		#1;
		chk({o_bridge_a, o_bridge_b, o_in_power}, 32'h0);
		// enable still high: a fresh ping starts at once from the start point
		chk({o_drive_on, o_freq_hz, o_duty}, {1'b1, 18'h2AB98, 9'h1F4});
		report_and_stop();
	end

endmodule : tb_inductive_tx_power_loop

`default_nettype wire
